// ===== bench/bmdc_bus_model.sv
// partner: bus-side engine that reports transaction boundaries
`timescale 1ns/1ps
module bmdc_bus_model (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// controls from the bench and the block
	input  wire logic i_req,
	input  wire logic i_slow,
	input  wire logic i_enable,
	// status back to the block
	output logic      o_xact_idle,
	output logic      o_busy
);
	logic [2:0] cnt_reg;

	// a burst restarts each cycle while enabled and requested; it ends 1 or 6 cycles later
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			cnt_reg <= 3'h0;
		else if (i_enable && i_req)
			cnt_reg <= i_slow ? 3'h6 : 3'h1;
		else if (cnt_reg != 3'h0)
			cnt_reg <= cnt_reg - 3'h1;
	end
	assign o_xact_idle = (cnt_reg == 3'h0);
	assign o_busy      = !o_xact_idle;
endmodule

// ===== bench/bus_master_dma_control_tb.sv
// testbench: dma control word, halts, options, completions and aborts
`timescale 1ns/1ps
module bus_master_dma_control_tb;
	typedef struct packed {
		logic [31:0] wd;
		logic [31:0] rd;
		logic        mwi;
	} bmdc_row_t;
	logic        i_clk, i_reset, i_ctrl_wr, i_rstctl_wr, tx_req, tx_slow;
	logic [31:0] i_ctrl_wdata, i_rstctl_wdata, o_ctrl_rdata;
	logic        i_rx_fifo_full, i_tx_done_indicate_field;
	logic        i_write_wants_mwi, o_use_mwi, o_reset_in_progress;
	logic        o_rx_done_status, o_tx_done_status, o_rx_enable;
	logic        o_tx_enable, o_rx_frame_drop, rx_idle, tx_idle, tx_busy;
	logic [8:0]  ev;
	wire logic   i_rx_done_event, i_tx_done_event, i_rx_done_ack;
	wire logic   i_tx_done_ack, i_rx_desc_done_seen, i_rx_frame_data;
	wire logic   i_rx_frame_end, i_bus_target_abort, i_bus_master_abort;
	int          errors, n_checks;
	bmdc_row_t   rows [4] = '{
		'{32'h0010_0000, 32'h0010_0000, 1'b0},
		'{32'h0040_0000, 32'h0040_0000, 1'b1},
		'{32'h0000_0000, 32'h0000_0000, 1'b1},
		'{32'h0000_0200, 32'h0000_0000, 1'b1}};

	assign {i_rx_done_event, i_tx_done_event, i_rx_done_ack, i_tx_done_ack,
		i_rx_desc_done_seen, i_rx_frame_data, i_rx_frame_end,
		i_bus_target_abort, i_bus_master_abort} = ev;

	bmdc_dma_control i_bmdc_dma_control (
		.i_clk, .i_reset, .i_ctrl_wr, .i_ctrl_wdata, .o_ctrl_rdata,
		.i_rstctl_wr, .i_rstctl_wdata, .o_reset_in_progress,
		.i_rx_done_event, .i_tx_done_event, .i_rx_done_ack, .i_tx_done_ack,
		.o_rx_done_status, .o_tx_done_status, .i_rx_desc_done_seen,
		.i_rx_xact_idle(rx_idle), .i_rx_fifo_full, .i_rx_frame_data,
		.i_rx_frame_end, .o_rx_enable, .o_rx_frame_drop,
		.i_tx_done_indicate_field, .i_tx_busy(tx_busy),
		.i_tx_xact_idle(tx_idle), .o_tx_enable, .i_bus_target_abort,
		.i_bus_master_abort, .i_write_wants_mwi, .o_use_mwi);
	bmdc_bus_model i_rx_model (.i_clk, .i_reset, .i_req(tx_req),
		.i_slow(tx_slow), .i_enable(o_rx_enable), .o_xact_idle(rx_idle),
		.o_busy());
	bmdc_bus_model i_tx_model (.i_clk, .i_reset, .i_req(tx_req),
		.i_slow(tx_slow), .i_enable(o_tx_enable), .o_xact_idle(tx_idle),
		.o_busy(tx_busy));

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// ==========================================================
	// tasks
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [31:0] d);
		@(posedge i_clk);
		i_ctrl_wr <= 1'b1;
		i_ctrl_wdata <= d;
		@(posedge i_clk);
		i_ctrl_wr <= 1'b0;
		#1;
	endtask
	task automatic rst(input logic [31:0] d);
		@(posedge i_clk);
		i_rstctl_wr <= 1'b1;
		i_rstctl_wdata <= d;
		@(posedge i_clk);
		i_rstctl_wr <= 1'b0;
		#1;
	endtask
	task automatic pulse(input int b);
		@(posedge i_clk);
		ev <= 9'h001 << b;
		@(posedge i_clk);
		ev <= 9'h000;
		#1;
	endtask
	// b below 32 waits for that status bit, 32 waits for reset to finish
	task automatic wait_for(input int b);
		int n;
		n = 0;
		while (n < 40 && ((b < 32) ? o_ctrl_rdata[b] !== 1'b1
			: o_reset_in_progress !== 1'b0)) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 40) begin
			errors++;
			end_sim();
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{i_reset, i_write_wants_mwi} = 2'h3;
		{i_ctrl_wr, i_rstctl_wr, tx_req, tx_slow, i_rx_fifo_full} = '0;
		i_tx_done_indicate_field = 1'b0;
		{i_ctrl_wdata, i_rstctl_wdata, ev} = '0;
		repeat (10) @(posedge i_clk);
		i_reset <= 1'b0;
		#1;
		chk("rdata", o_ctrl_rdata, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(rows[i].wd);
			chk("rdata", o_ctrl_rdata, rows[i].rd);
			chk("mwi", o_use_mwi, rows[i].mwi);
		end
		// slow transmit halt, then underrun recovery order
		@(posedge i_clk);
		tx_slow <= 1'b1;
		tx_req <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		chk("tx active", o_ctrl_rdata[14], 1'b1);
		wr(32'h0000_0400);
		chk("stop pending", o_ctrl_rdata[15], 1'b1);
		chk("tx enable", o_tx_enable, 1'b0);
		wait_for(2);
		chk("pending", o_ctrl_rdata[15:14], 2'h0);
		rst(32'h0004_0000);
		chk("reset busy", o_reset_in_progress, 1'b1);
		wait_for(32);
		chk("tx stopped", o_ctrl_rdata[2], 1'b1);
		@(posedge i_clk);
		tx_slow <= 1'b0;
		wr(32'h0000_0800);
		chk("tx stopped", o_ctrl_rdata[2], 1'b0);
		chk("tx enable", o_tx_enable, 1'b1);
		// receive halt by command and by a completed descriptor
		for (int k = 0; k < 2; k++) begin
			if (k == 0)
				wr(32'h0000_0100);
			else
				pulse(4);
			wait_for(0);
			chk("rx enable", o_rx_enable, 1'b0);
			wr(32'h0000_0200);
			chk("rx stopped", o_ctrl_rdata[0], 1'b0);
			chk("rx enable", o_rx_enable, 1'b1);
		end
		// completions, rx then tx
		for (int k = 0; k < 2; k++) begin
			pulse(8 - k);
			chk("done", o_ctrl_rdata[3 + k], 1'b1);
			chk("irq", {o_tx_done_status, o_rx_done_status},
				2'h1 << k);
			pulse(6 - k);
			chk("done", o_ctrl_rdata[4:3], 2'h0);
		end
		@(posedge i_clk);
		i_tx_done_indicate_field <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		chk("tx done req", o_ctrl_rdata[1], 1'b1);
		// overflow frames, dropped then passed
		for (int k = 0; k < 2; k++) begin
			wr(k == 0 ? 32'h0 : 32'h0040_0000);
			@(posedge i_clk);
			i_rx_fifo_full <= 1'b1;
			pulse(3);
			chk("drop", o_rx_frame_drop, k == 0);
			pulse(2);
			@(posedge i_clk);
			i_rx_fifo_full <= 1'b0;
		end
		// fatal aborts, target then master
		for (int k = 0; k < 2; k++) begin
			pulse(1 - k);
			chk("abort", o_ctrl_rdata[30 + k], 1'b1);
			chk("enables", {o_rx_enable, o_tx_enable}, 2'h0);
			rst(32'h0001_0000);
			wait_for(32);
			chk("abort", o_ctrl_rdata[30 + k], 1'b1);
			rst(32'h0009_0000);
			wait_for(32);
			chk("abort", o_ctrl_rdata[31:30], 2'h0);
			chk("options", o_ctrl_rdata[22:20], 3'h0);
			chk("enables", {o_rx_enable, o_tx_enable}, 2'h3);
		end
		// reset in mid run
		wr(32'h0050_0000);
		@(posedge i_clk);
		i_reset <= 1'b1;
		#1;
		chk("rdata", o_ctrl_rdata, 32'h0);
		@(posedge i_clk);
		i_reset <= 1'b0;
		wr(32'h0010_0000);
		chk("wi off", o_ctrl_rdata[20], 1'b1);
		chk("enables", {o_rx_enable, o_tx_enable}, 2'h3);
		end_sim();
	end
endmodule

// ===== src/bmdc_dma_control.sv
// dma control and status word for the receive and transmit bus masters
//
// Contract
// - rx stopped bit sets on stop command or descriptor already complete.
// - rx restart write clears rx stopped bit and receive continues.
// - tx done request bit follows current tx descriptor indicate field.
// - tx stopped bit set by tx stop, cleared by tx restart.
// - rx done latched on frame transfer end, mirrors interrupt, acked clear.
// - tx done equals tx interrupt status bit, cleared by acknowledge.
// - writing one to rx stop halts receive; self clearing; zero ignored.
// - writing one to rx restart restarts receive; self clearing.
// - writing one to tx stop halts transmit; self clearing.
// - writing one to tx restart restarts transmit; self clearing.
// - tx active reads one while a transmit dma is under way.
// - stop pending stays high while any halt is being carried out.
// - write invalidate off forbids memory write invalidate commands.
// - overflow frames dropped unless pass option set, then transferred.
// - frame is overflow if any part arrives while rx fifo full.
// - target abort sets fatal flag blocking all dma.
// - master abort sets fatal flag blocking all dma.
// - abort flags clear only by whole reset with dma select.
// - all control word bits are zero after reset.
// - dma select decides if dma state joins a reset; self clearing.
`timescale 1ns/1ps
module bmdc_dma_control (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// register port: dma control word
	input  wire logic        i_ctrl_wr,
	input  wire logic [31:0] i_ctrl_wdata,
	output logic      [31:0] o_ctrl_rdata,
	// register port: chip reset control write
	input  wire logic        i_rstctl_wr,
	input  wire logic [31:0] i_rstctl_wdata,
	output logic             o_reset_in_progress,
	// interrupt status bits and their acknowledge
	input  wire logic        i_rx_done_event,
	input  wire logic        i_tx_done_event,
	input  wire logic        i_rx_done_ack,
	input  wire logic        i_tx_done_ack,
	output logic             o_rx_done_status,
	output logic             o_tx_done_status,
	// receive engine
	input  wire logic        i_rx_desc_done_seen,
	input  wire logic        i_rx_xact_idle,
	input  wire logic        i_rx_fifo_full,
	input  wire logic        i_rx_frame_data,
	input  wire logic        i_rx_frame_end,
	output logic             o_rx_enable,
	output logic             o_rx_frame_drop,
	// transmit engine
	input  wire logic        i_tx_done_indicate_field,
	input  wire logic        i_tx_busy,
	input  wire logic        i_tx_xact_idle,
	output logic             o_tx_enable,
	// bus master
	input  wire logic        i_bus_target_abort,
	input  wire logic        i_bus_master_abort,
	input  wire logic        i_write_wants_mwi,
	output logic             o_use_mwi
);
	// every assertion below runs on the one clock, idle while reset is high
	default clocking bmdc_cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	// ==========================================================
	// state
	typedef struct packed {
		logic       rx_done;
		logic       tx_done;
		logic       tx_req;
		logic       tx_active;
		logic       wi_off;
		logic       pass_ovf;
		logic       tabort;
		logic       mabort;
		logic       ovf_frame;
		logic [3:0] rst_cnt;
	} bmdc_state_t;
	bmdc_state_t s_reg;
	bmdc_state_t s_next;

	logic rx_stop_cmd;
	logic rx_restart_cmd;
	logic tx_stop_cmd;
	logic tx_restart_cmd;
	logic dma_clear;
	logic any_reset;
	logic rx_stopped;
	logic tx_stopped;
	logic rx_draining;
	logic tx_draining;
	logic rx_run;
	logic tx_run;
	logic fatal;
	logic abort_clear;

	function automatic logic wbit(input logic [31:0] d, input int b);
		wbit = d[b];
	endfunction

	// ==========================================================
	// command decode
	// self-clearing commands: only a one in the written word acts
	assign rx_stop_cmd    = i_ctrl_wr &&
		wbit(i_ctrl_wdata, bmdc_pkg::RX_STOP_CMD_BIT);
	assign rx_restart_cmd = i_ctrl_wr &&
		wbit(i_ctrl_wdata, bmdc_pkg::RX_RESTART_BIT);
	assign tx_stop_cmd    = i_ctrl_wr &&
		wbit(i_ctrl_wdata, bmdc_pkg::TX_STOP_CMD_BIT);
	assign tx_restart_cmd = i_ctrl_wr &&
		wbit(i_ctrl_wdata, bmdc_pkg::TX_RESTART_BIT);

	// dma state joins a reset only when the select bit is written with it
	assign any_reset = i_rstctl_wr && (
		wbit(i_rstctl_wdata, bmdc_pkg::WHOLE_RESET_BIT) ||
		wbit(i_rstctl_wdata, bmdc_pkg::RX_RESET_BIT) ||
		wbit(i_rstctl_wdata, bmdc_pkg::TX_RESET_BIT));
	assign dma_clear = any_reset &&
		wbit(i_rstctl_wdata, bmdc_pkg::DMA_SEL_BIT);
	// abort flags need the whole reset together with the dma select
	assign abort_clear = dma_clear &&
		wbit(i_rstctl_wdata, bmdc_pkg::WHOLE_RESET_BIT);

	// ==========================================================
	// engine sequencers
	bmdc_engine_ctl u_rx (
		.i_clk           (i_clk),
		.i_reset         (i_reset),
		.i_sync_clear    (dma_clear),
		.i_stop          (rx_stop_cmd),
		.i_restart       (rx_restart_cmd),
		.i_implicit_stop (i_rx_desc_done_seen),
		.i_xact_idle     (i_rx_xact_idle),
		.o_stopped       (rx_stopped),
		.o_draining      (rx_draining),
		.o_run           (rx_run)
	);

	bmdc_engine_ctl u_tx (
		.i_clk           (i_clk),
		.i_reset         (i_reset),
		.i_sync_clear    (dma_clear),
		.i_stop          (tx_stop_cmd),
		.i_restart       (tx_restart_cmd),
		.i_implicit_stop (1'b0),
		.i_xact_idle     (i_tx_xact_idle),
		.o_stopped       (tx_stopped),
		.o_draining      (tx_draining),
		.o_run           (tx_run)
	);

	// ==========================================================
	// next state
	always_comb begin
		s_next = s_reg;
		// completion flags: set wins over acknowledge
		if (i_rx_done_event) begin
			s_next.rx_done = 1'b1;
		end else if (i_rx_done_ack) begin
			s_next.rx_done = 1'b0;
		end
		if (i_tx_done_event) begin
			s_next.tx_done = 1'b1;
		end else if (i_tx_done_ack) begin
			s_next.tx_done = 1'b0;
		end
		s_next.tx_req    = i_tx_done_indicate_field;
		s_next.tx_active = i_tx_busy;
		if (i_ctrl_wr) begin
			s_next.wi_off   = wbit(i_ctrl_wdata, bmdc_pkg::WI_OFF_BIT);
			s_next.pass_ovf = wbit(i_ctrl_wdata, bmdc_pkg::PASS_OVF_BIT);
		end
		// overflow marking for the frame in flight
		if (i_rx_frame_data && i_rx_fifo_full) begin
			s_next.ovf_frame = 1'b1;
		end else if (i_rx_frame_end) begin
			s_next.ovf_frame = 1'b0;
		end
		// fatal abort flags, sticky until a whole reset with dma select
		if (i_bus_target_abort) begin
			s_next.tabort = 1'b1;
		end else if (dma_clear &&
			wbit(i_rstctl_wdata, bmdc_pkg::WHOLE_RESET_BIT)) begin
			s_next.tabort = 1'b0;
		end
		if (i_bus_master_abort) begin
			s_next.mabort = 1'b1;
		end else if (dma_clear &&
			wbit(i_rstctl_wdata, bmdc_pkg::WHOLE_RESET_BIT)) begin
			s_next.mabort = 1'b0;
		end
		if (dma_clear) begin
			s_next.rx_done  = 1'b0;
			s_next.tx_done  = 1'b0;
			s_next.wi_off   = 1'b0;
			s_next.pass_ovf = 1'b0;
		end
		if (any_reset) begin
			s_next.rst_cnt = bmdc_pkg::RESET_CYCLES;
		end else if (s_reg.rst_cnt != 4'h0) begin
			s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs
	assign fatal = s_reg.tabort || s_reg.mabort;
	assign o_rx_enable = rx_run && !fatal;
	assign o_tx_enable = tx_run && !fatal;
	// overflow frame is dropped unless passing is enabled
	assign o_rx_frame_drop = (s_reg.ovf_frame ||
		(i_rx_frame_data && i_rx_fifo_full)) && !s_reg.pass_ovf;
	assign o_use_mwi = i_write_wants_mwi && !s_reg.wi_off;
	assign o_rx_done_status = s_reg.rx_done;
	assign o_tx_done_status = s_reg.tx_done;
	assign o_reset_in_progress = (s_reg.rst_cnt != 4'h0);

	always_comb begin
		o_ctrl_rdata = bmdc_pkg::DMA_CTRL_RESET;
		o_ctrl_rdata[bmdc_pkg::RX_STOPPED_BIT]   = rx_stopped;
		o_ctrl_rdata[bmdc_pkg::TX_DONE_REQ_BIT]  = s_reg.tx_req;
		o_ctrl_rdata[bmdc_pkg::TX_STOPPED_BIT]   = tx_stopped;
		o_ctrl_rdata[bmdc_pkg::RX_DONE_BIT]      = s_reg.rx_done;
		o_ctrl_rdata[bmdc_pkg::TX_DONE_BIT]      = s_reg.tx_done;
		o_ctrl_rdata[bmdc_pkg::TX_ACTIVE_BIT]    = s_reg.tx_active;
		o_ctrl_rdata[bmdc_pkg::STOP_PENDING_BIT] =
			rx_draining || tx_draining;
		o_ctrl_rdata[bmdc_pkg::WI_OFF_BIT]       = s_reg.wi_off;
		o_ctrl_rdata[bmdc_pkg::PASS_OVF_BIT]     = s_reg.pass_ovf;
		o_ctrl_rdata[bmdc_pkg::TABORT_BIT]       = s_reg.tabort;
		o_ctrl_rdata[bmdc_pkg::MABORT_BIT]       = s_reg.mabort;
	end

	// ==========================================================
	// assertions
	// a stop command taken while the engine runs
	sequence rx_stop_seq;
		rx_stop_cmd && rx_run && !dma_clear;
	endsequence
	sequence tx_stop_seq;
		tx_stop_cmd && tx_run && !dma_clear;
	endsequence
	// draining engine meets a transaction boundary
	sequence rx_edge_seq;
		rx_draining && i_rx_xact_idle && !dma_clear;
	endsequence
	sequence tx_edge_seq;
		tx_draining && i_tx_xact_idle && !dma_clear;
	endsequence
	// draining engine still inside a transaction
	sequence rx_open_seq;
		rx_draining && !i_rx_xact_idle && !dma_clear;
	endsequence
	sequence tx_open_seq;
		tx_draining && !i_tx_xact_idle && !dma_clear;
	endsequence
	// data beat into a full fifo, then passing still off
	sequence ovf_seq;
		i_rx_frame_data && i_rx_fifo_full ##1 !s_reg.pass_ovf;
	endsequence

	a_rx_stop_pending: assert property (
		rx_stop_seq |=> o_ctrl_rdata[bmdc_pkg::STOP_PENDING_BIT])
		else $error("stop pending not raised after rx stop");
	a_tx_stop_pending: assert property (
		tx_stop_seq |=> o_ctrl_rdata[bmdc_pkg::STOP_PENDING_BIT])
		else $error("stop pending not raised after tx stop");
	a_rx_stop_halts: assert property (
		rx_stop_seq |=> !o_rx_enable)
		else $error("rx stop did not halt receive");
	a_tx_stop_halts: assert property (
		tx_stop_seq |=> !o_tx_enable)
		else $error("tx stop did not halt transmit");
	a_rx_stopped_idle: assert property (
		rx_edge_seq |=> o_ctrl_rdata[bmdc_pkg::RX_STOPPED_BIT])
		else $error("rx did not stop at boundary");
	a_tx_stopped_idle: assert property (
		tx_edge_seq |=> o_ctrl_rdata[bmdc_pkg::TX_STOPPED_BIT])
		else $error("tx did not stop at boundary");
	a_rx_wait_edge: assert property (
		rx_open_seq |=> !o_ctrl_rdata[bmdc_pkg::RX_STOPPED_BIT] &&
		o_ctrl_rdata[bmdc_pkg::STOP_PENDING_BIT])
		else $error("rx stopped inside a transaction");
	a_tx_wait_edge: assert property (
		tx_open_seq |=> !o_ctrl_rdata[bmdc_pkg::TX_STOPPED_BIT] &&
		o_ctrl_rdata[bmdc_pkg::STOP_PENDING_BIT])
		else $error("tx stopped inside a transaction");
	a_rx_restart_clr: assert property (
		rx_stopped && rx_restart_cmd |=> !rx_stopped && o_rx_enable == !fatal)
		else $error("rx restart did not clear stopped");
	a_rx_stop_holds: assert property (
		rx_stopped && !rx_restart_cmd && !dma_clear |=> rx_stopped)
		else $error("rx left stopped without restart");
	a_tx_restart_clr: assert property (
		tx_stopped && tx_restart_cmd
		|=> !o_ctrl_rdata[bmdc_pkg::TX_STOPPED_BIT])
		else $error("tx restart did not clear stopped");
	a_tx_stop_holds: assert property (
		tx_stopped && !tx_restart_cmd && !dma_clear |=> tx_stopped)
		else $error("tx left stopped without restart");
	a_rx_done_hold: assert property (
		i_rx_done_event && !dma_clear |=> o_rx_done_status)
		else $error("rx done lost");
	a_rx_done_ack: assert property (
		i_rx_done_ack && !i_rx_done_event && !dma_clear
		|=> !o_rx_done_status)
		else $error("rx done not cleared by ack");
	a_tx_done_hold: assert property (
		i_tx_done_event && !dma_clear |=> o_tx_done_status)
		else $error("tx done lost");
	a_tx_done_ack: assert property (
		i_tx_done_ack && !i_tx_done_event && !dma_clear
		|=> !o_tx_done_status)
		else $error("tx done not cleared by ack");
	a_abort_fatal: assert property (
		i_bus_target_abort || i_bus_master_abort
		|=> !o_rx_enable && !o_tx_enable)
		else $error("dma not blocked after abort");
	a_master_abort: assert property (
		i_bus_master_abort
		|=> o_ctrl_rdata[bmdc_pkg::MABORT_BIT] && !o_rx_enable)
		else $error("master abort not held as fatal");
	a_abort_sticky: assert property (
		o_ctrl_rdata[bmdc_pkg::TABORT_BIT] && !abort_clear
		|=> o_ctrl_rdata[bmdc_pkg::TABORT_BIT])
		else $error("target abort cleared without dma reset");
	a_abort_clear: assert property (
		abort_clear && !i_bus_target_abort && !i_bus_master_abort
		|=> !o_ctrl_rdata[bmdc_pkg::TABORT_BIT] && !o_ctrl_rdata[bmdc_pkg::MABORT_BIT])
		else $error("abort flags kept after dma reset");
	a_mwi_blocked: assert property (
		s_reg.wi_off |-> !o_use_mwi)
		else $error("mwi used while disabled");
	a_ovf_dropped: assert property (
		ovf_seq |-> o_rx_frame_drop)
		else $error("overflow frame not dropped");
	a_ovf_passed: assert property (
		s_reg.pass_ovf |-> !o_rx_frame_drop)
		else $error("overflow frame dropped while passing");
	a_reset_busy: assert property (
		any_reset |=> o_reset_in_progress)
		else $error("reset in progress not raised");
	a_tx_active_mirror: assert property (
		i_tx_busy |=> o_ctrl_rdata[bmdc_pkg::TX_ACTIVE_BIT])
		else $error("tx active not shown");
endmodule

// ===== src/bmdc_engine_ctl.sv
// one dma engine's run / drain / stopped sequencer
`timescale 1ns/1ps
module bmdc_engine_ctl (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_sync_clear,
	// commands and events
	input  wire logic i_stop,
	input  wire logic i_restart,
	input  wire logic i_implicit_stop,
	input  wire logic i_xact_idle,
	// status
	output logic      o_stopped,
	output logic      o_draining,
	output logic      o_run
);
	typedef struct packed {
		bmdc_pkg::bmdc_eng_t st;
	} bmdc_ec_state_t;
	bmdc_ec_state_t s_reg;
	bmdc_ec_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (i_sync_clear) begin
			s_next.st = bmdc_pkg::BMDC_RUN;
		end else begin
			case (s_reg.st)
			bmdc_pkg::BMDC_RUN: begin
				if (i_stop || i_implicit_stop) begin
					s_next.st = bmdc_pkg::BMDC_DRAIN;
				end
			end
			bmdc_pkg::BMDC_DRAIN: begin
				// stop only at a transaction boundary
				if (i_xact_idle) begin
					s_next.st = bmdc_pkg::BMDC_STOPPED;
				end
			end
			bmdc_pkg::BMDC_STOPPED: begin
				if (i_restart) begin
					s_next.st = bmdc_pkg::BMDC_RUN;
				end
			end
			default: s_next.st = bmdc_pkg::BMDC_RUN;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_reg.st <= bmdc_pkg::BMDC_RUN;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_stopped  = (s_reg.st == bmdc_pkg::BMDC_STOPPED);
	assign o_draining = (s_reg.st == bmdc_pkg::BMDC_DRAIN);
	assign o_run      = (s_reg.st == bmdc_pkg::BMDC_RUN);
endmodule

// ===== src/bmdc_pkg.sv
// package: field positions, offsets and timing for the dma control word
package bmdc_pkg;
	localparam logic [7:0] DMA_CTRL_OFFSET   = 8'h00;
	localparam int RX_STOPPED_BIT   = 0;
	localparam int TX_DONE_REQ_BIT  = 1;
	localparam int TX_STOPPED_BIT   = 2;
	localparam int RX_DONE_BIT      = 3;
	localparam int TX_DONE_BIT      = 4;
	localparam int RX_STOP_CMD_BIT  = 8;
	localparam int RX_RESTART_BIT   = 9;
	localparam int TX_STOP_CMD_BIT  = 10;
	localparam int TX_RESTART_BIT   = 11;
	localparam int TX_ACTIVE_BIT    = 14;
	localparam int STOP_PENDING_BIT = 15;
	localparam int WI_OFF_BIT       = 20;
	localparam int PASS_OVF_BIT     = 22;
	localparam int TABORT_BIT       = 30;
	localparam int MABORT_BIT       = 31;
	localparam logic [31:0] DMA_CTRL_RESET = 32'h0000_0000;
	// chip_reset_control bit positions used here
	localparam int WHOLE_RESET_BIT  = 16;
	localparam int RX_RESET_BIT     = 17;
	localparam int TX_RESET_BIT     = 18;
	localparam int DMA_SEL_BIT      = 19;
	localparam int RESET_BUSY_BIT   = 26;
	// cycles the reset-in-progress flag stays up
	localparam logic [3:0] RESET_CYCLES = 4'h8;
	typedef enum logic [1:0] {
		BMDC_RUN,
		BMDC_DRAIN,
		BMDC_STOPPED
	} bmdc_eng_t;
endpackage
